//--- hdl/eca_map.svh
`ifndef ECA_MAP_SVH
`define ECA_MAP_SVH

// ********************************
// register offsets
// ********************************
`define ECA_OFS_CTRL 8'h00
`define ECA_OFS_DATA 8'h01
`define ECA_OFS_ADDR_LO 8'h02
`define ECA_OFS_ADDR_HI 8'h03

// ********************************
// control register fields
// ********************************
`define ECA_BIT_RE 0
`define ECA_BIT_WE 1
`define ECA_BIT_MWE 2
`define ECA_BIT_RIE 3

// ********************************
// reset values and sizes
// ********************************
`define ECA_RST_ADDR 9'h000
`define ECA_RST_DATA 8'h00
`define ECA_MEM_BYTES 512

// ********************************
// timing counts
// ********************************
`define ECA_READ_HALT 3'h4
`define ECA_WRITE_HALT 3'h2
`define ECA_MWE_WINDOW 3'h4
`define ECA_RC_WRITE_CYCLES 27072

`endif

//--- hdl/eca_pkg.sv
package eca_pkg;

  // ********************************
  // register bus request
  // ********************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } eca_bus_req_t;

  // ********************************
  // write sequencer states
  // ********************************
  typedef enum logic {
    st_idle,
    st_busy
  } eca_state_t;

endpackage : eca_pkg

//--- hdl/eca_write_timer.sv
`timescale 1ns/1ps
`default_nettype none

module eca_write_timer #(
  parameter int RC_CYCLES = 27072
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_rc_tick,
  output logic o_busy,
  output logic o_done
);

  localparam logic [14:0] LAST = 15'(RC_CYCLES - 1);

  logic [14:0] cnt_reg;
  logic [14:0] cnt_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;

  // ********************************
  // oscillator cycle counting
  // ********************************
  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (busy_reg) begin
      if (i_rc_tick) begin
        if (cnt_reg == LAST) begin
          busy_next = 1'b0;
          done_next = 1'b1;
          cnt_next = 15'h0000;
        end else begin
          cnt_next = cnt_reg + 15'h0001;
        end
      end
    end else if (i_start) begin
      busy_next = 1'b1;
      cnt_next = 15'h0000;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cnt_reg <= 15'h0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign o_busy = busy_reg;
  assign o_done = done_reg;

  // ********************************
  // checks
  // ********************************
  AST_TIMER_DONE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_done |-> $past(busy_reg) && $past(i_rc_tick) && $past(cnt_reg) == LAST)
    else $error("write timer ended early");

endmodule : eca_write_timer

`default_nettype wire

//--- hdl/eca_access_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "eca_map.svh"

module eca_access_ctrl #(
  parameter int RC_WRITE_CYCLES = `ECA_RC_WRITE_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire eca_pkg::eca_bus_req_t i_bus,
  input wire logic i_rc_tick,
  input wire logic i_flash_prog_busy,
  input wire logic i_global_int_en,
  output logic [7:0] o_rdata,
  output logic o_cpu_halt,
  output logic o_ready_irq
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ********************************
  // state
  // ********************************
  eca_pkg::eca_state_t state_reg;
  eca_pkg::eca_state_t state_next;
  logic [8:0] addr_reg;
  logic [8:0] addr_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic [8:0] wr_addr_reg;
  logic [8:0] wr_addr_next;
  logic [7:0] wr_data_reg;
  logic [7:0] wr_data_next;
  logic rie_reg;
  logic rie_next;
  logic [2:0] mwe_cnt_reg;
  logic [2:0] mwe_cnt_next;
  logic [2:0] halt_cnt_reg;
  logic [2:0] halt_cnt_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] mem_reg [0:`ECA_MEM_BYTES-1];

  logic ctrl_wr;
  logic mwe_on;
  logic busy;
  logic start;
  logic rd_go;
  logic mem_wr;
  logic tmr_done;

  assign ctrl_wr = i_bus.wr && hit(i_bus.addr, `ECA_OFS_CTRL);
  assign mwe_on = (mwe_cnt_reg != 3'h0);
  assign busy = (state_reg == eca_pkg::st_busy);
  assign start = ctrl_wr && i_bus.wdata[`ECA_BIT_WE] && mwe_on && !busy
    && !i_flash_prog_busy;
  assign rd_go = ctrl_wr && i_bus.wdata[`ECA_BIT_RE] && !busy && !start;
  assign mem_wr = busy && tmr_done;

  // ********************************
  // write timer
  // ********************************
  // start and done handshake
  eca_write_timer #(
    .RC_CYCLES(RC_WRITE_CYCLES)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_start(start),
    .i_rc_tick(i_rc_tick),
    .o_busy(),
    .o_done(tmr_done)
  );

  // ********************************
  // next values
  // ********************************
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    rie_next = rie_reg;
    mwe_cnt_next = mwe_cnt_reg;
    halt_cnt_next = halt_cnt_reg;
    rdata_next = 8'h00;
    if (halt_cnt_reg != 3'h0) begin
      halt_cnt_next = halt_cnt_reg - 3'h1;
    end
    if (ctrl_wr && i_bus.wdata[`ECA_BIT_MWE]) begin
      mwe_cnt_next = `ECA_MWE_WINDOW;
    end else if (mwe_on) begin
      mwe_cnt_next = mwe_cnt_reg - 3'h1;
    end
    if (ctrl_wr) begin
      rie_next = i_bus.wdata[`ECA_BIT_RIE];
    end
    if (i_bus.wr && hit(i_bus.addr, `ECA_OFS_DATA)) begin
      data_next = i_bus.wdata;
    end
    if (i_bus.wr && !busy && hit(i_bus.addr, `ECA_OFS_ADDR_LO)) begin
      addr_next[7:0] = i_bus.wdata;
    end
    if (i_bus.wr && !busy && hit(i_bus.addr, `ECA_OFS_ADDR_HI)) begin
      addr_next[8] = i_bus.wdata[0];
    end
    if (start) begin
      state_next = eca_pkg::st_busy;
      wr_addr_next = addr_reg;
      wr_data_next = data_reg;
      halt_cnt_next = `ECA_WRITE_HALT;
    end
    if (rd_go) begin
      data_next = mem_reg[addr_reg];
      halt_cnt_next = `ECA_READ_HALT;
    end
    if (mem_wr) begin
      state_next = eca_pkg::st_idle;
    end
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        `ECA_OFS_CTRL: rdata_next = {4'h0, rie_reg, mwe_on, busy, 1'b0};
        `ECA_OFS_DATA: rdata_next = data_reg;
        `ECA_OFS_ADDR_LO: rdata_next = addr_reg[7:0];
        `ECA_OFS_ADDR_HI: rdata_next = {7'h00, addr_reg[8]};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_reg <= eca_pkg::st_idle;
      addr_reg <= `ECA_RST_ADDR;
      data_reg <= `ECA_RST_DATA;
      wr_addr_reg <= `ECA_RST_ADDR;
      wr_data_reg <= `ECA_RST_DATA;
      rie_reg <= 1'b0;
      mwe_cnt_reg <= 3'h0;
      halt_cnt_reg <= 3'h0;
      rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      rie_reg <= rie_next;
      mwe_cnt_reg <= mwe_cnt_next;
      halt_cnt_reg <= halt_cnt_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (mem_wr) begin
      mem_reg[wr_addr_reg] <= wr_data_reg;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign o_rdata = rdata_reg;
  assign o_cpu_halt = (halt_cnt_reg != 3'h0);
  assign o_ready_irq = rie_reg && i_global_int_en && !busy;

  // ********************************
  // checks
  // ********************************
  sequence seq_read_quiet;
    rd_go ##1 !ctrl_wr [*4];
  endsequence

  sequence seq_write_quiet;
    start ##1 !ctrl_wr [*2];
  endsequence

  sequence seq_mwe_quiet;
    ctrl_wr && i_bus.wdata[`ECA_BIT_MWE]
      ##1 !(ctrl_wr && i_bus.wdata[`ECA_BIT_MWE]) [*4];
  endsequence

  AST_READ_HALT: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    seq_read_quiet |-> o_cpu_halt ##1 !o_cpu_halt)
    else $error("read halt length wrong");

  AST_READ_HALT_LEN: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    seq_read_quiet |-> $past(o_cpu_halt, 3))
    else $error("read did not halt four cycles");

  AST_WRITE_HALT: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    seq_write_quiet |-> o_cpu_halt ##1 !o_cpu_halt)
    else $error("write halt length wrong");

  AST_WRITE_HALT_SEQ: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    seq_write_quiet |-> $past(o_cpu_halt) && busy)
    else $error("write halt did not start at once");

  AST_MWE_WINDOW: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    seq_mwe_quiet |-> mwe_on && $past(mwe_on, 3) ##1 !mwe_on)
    else $error("master enable window not four cycles");

  AST_LATE_STROBE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    ctrl_wr && i_bus.wdata[`ECA_BIT_WE] && !mwe_on && !busy |=> !busy)
    else $error("write started without master enable");

  AST_FLASH_BLOCK: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_flash_prog_busy && !busy |=> !busy)
    else $error("write started during flash programming");

  AST_ADDR_LOCK: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    busy |=> $stable(addr_reg))
    else $error("address changed during write");

  AST_READ_IGNORED: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    busy && ctrl_wr && i_bus.wdata[`ECA_BIT_RE] |=> $stable(data_reg)
      && halt_cnt_reg != `ECA_READ_HALT)
    else $error("read taken during write");

  AST_READ_DATA: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    rd_go |=> data_reg == mem_reg[$past(addr_reg)])
    else $error("read data not loaded");

  AST_STROBE_CLEAR: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    mem_wr |=> !busy && mem_reg[$past(wr_addr_reg)] == $past(wr_data_reg))
    else $error("write strobe did not clear after write");

  AST_READY_IRQ: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    start |=> !o_ready_irq)
    else $error("ready interrupt not dropped at write start");

  AST_READY_IRQ_END: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    mem_wr && rie_reg && i_global_int_en && !ctrl_wr
      |=> o_ready_irq || !i_global_int_en)
    else $error("ready interrupt missing after write");

endmodule : eca_access_ctrl

`default_nettype wire

//--- bench/eca_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module eca_cpu_model (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  output eca_pkg::eca_bus_req_t o_bus,
  output logic o_rc_tick
);
  // ****************
  // oscillator tick, every second cycle
  // ****************
  initial begin
    o_bus = '0;
    o_rc_tick = 1'b0;
    forever begin
      @(posedge i_clk_sys);
      o_rc_tick <= ~o_rc_tick;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    o_bus <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    o_bus <= '0;
    #1;
    d = i_rdata;
  endtask : rd
endmodule : eca_cpu_model

`default_nettype wire

//--- bench/eca_access_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error %0t got %0h exp %0h", $time, a, b); end end

module eca_access_ctrl_tb_top;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_flash_prog_busy = 1'b0;
  logic i_global_int_en = 1'b0;
  logic i_rc_tick;
  logic [7:0] o_rdata;
  logic o_cpu_halt;
  logic o_ready_irq;
  eca_pkg::eca_bus_req_t i_bus;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  logic [7:0] v;

  always #4 i_clk_sys = ~i_clk_sys;

  eca_cpu_model cpu (
    .i_clk_sys(i_clk_sys),
    .i_rdata(o_rdata),
    .o_bus(i_bus),
    .o_rc_tick(i_rc_tick)
  );

  eca_access_ctrl #(.RC_WRITE_CYCLES(20)) dut (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_bus(i_bus),
    .i_rc_tick(i_rc_tick),
    .i_flash_prog_busy(i_flash_prog_busy),
    .i_global_int_en(i_global_int_en),
    .o_rdata(o_rdata),
    .o_cpu_halt(o_cpu_halt),
    .o_ready_irq(o_ready_irq)
  );

  // ****************
  // helpers
  // ****************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic halt_cnt(output int k);
    k = 0;
    repeat (8) begin
      #1;
      if (o_cpu_halt === 1'b1) k++;
      @(posedge i_clk_sys);
    end
  endtask : halt_cnt

  task automatic wait_idle(output int k);
    logic [7:0] c;
    k = 0;
    c = 8'h02;
    while (c[1] !== 1'b0 && k < 200) begin
      cpu.rd(8'h00, c);
      k++;
    end
  endtask : wait_idle

  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    cpu.rd(8'h00, v);
    `CHK(v, 8'h00)
    cpu.rd(8'h01, v);
    `CHK(v, 8'h00)
    cpu.rd(8'h02, v);
    `CHK(v, 8'h00)
    cpu.rd(8'h10, v);
    `CHK(v, 8'h00)
    `CHK(o_ready_irq, 1'b0)
    `CHK(o_cpu_halt, 1'b0)
    $display("t_reset done");
  endtask : t_reset

  task automatic t_write();
    @(posedge i_clk_sys);
    i_global_int_en <= 1'b1;
    cpu.wr(8'h00, 8'h08);
    #1;
    `CHK(o_ready_irq, 1'b1)
    cpu.wr(8'h02, 8'hff);
    cpu.wr(8'h03, 8'h01);
    cpu.wr(8'h01, 8'ha5);
    cpu.wr(8'h00, 8'h0c);
    repeat (2) @(posedge i_clk_sys);
    cpu.wr(8'h00, 8'h0a);
    halt_cnt(n);
    `CHK(n, 2)
    cpu.rd(8'h00, v);
    `CHK(v[1], 1'b1)
    `CHK(o_ready_irq, 1'b0)
    wait_idle(n);
    `CHK(n >= 12 && n <= 18, 1'b1)
    `CHK(o_ready_irq, 1'b1)
    cpu.rd(8'h03, v);
    `CHK(v, 8'h01)
    @(posedge i_clk_sys);
    i_global_int_en <= 1'b0;
    #1;
    `CHK(o_ready_irq, 1'b0)
    cpu.wr(8'h01, 8'h00);
    cpu.wr(8'h00, 8'h01);
    halt_cnt(n);
    `CHK(n, 4)
    cpu.rd(8'h01, v);
    `CHK(v, 8'ha5)
    $display("t_write done");
  endtask : t_write

  task automatic t_late();
    cpu.wr(8'h00, 8'h04);
    cpu.rd(8'h00, v);
    `CHK(v, 8'h04)
    cpu.rd(8'h00, v);
    `CHK(v, 8'h04)
    cpu.rd(8'h00, v);
    `CHK(v, 8'h00)
    cpu.wr(8'h00, 8'h02);
    halt_cnt(n);
    `CHK(n, 0)
    cpu.rd(8'h00, v);
    `CHK(v[1], 1'b0)
    cpu.wr(8'h00, 8'h04);
    repeat (3) @(posedge i_clk_sys);
    cpu.wr(8'h00, 8'h02);
    halt_cnt(n);
    `CHK(n, 0)
    cpu.rd(8'h00, v);
    `CHK(v[1], 1'b0)
    $display("t_late done");
  endtask : t_late

  task automatic t_flash();
    @(posedge i_clk_sys);
    i_flash_prog_busy <= 1'b1;
    cpu.wr(8'h00, 8'h04);
    cpu.wr(8'h00, 8'h02);
    halt_cnt(n);
    `CHK(n, 0)
    cpu.rd(8'h00, v);
    `CHK(v[1], 1'b0)
    @(posedge i_clk_sys);
    i_flash_prog_busy <= 1'b0;
    $display("t_flash done");
  endtask : t_flash

  task automatic t_lock();
    cpu.wr(8'h02, 8'h05);
    cpu.wr(8'h03, 8'h00);
    cpu.wr(8'h01, 8'h3c);
    cpu.wr(8'h00, 8'h04);
    cpu.wr(8'h00, 8'h02);
    cpu.wr(8'h02, 8'h77);
    cpu.wr(8'h01, 8'h99);
    cpu.wr(8'h00, 8'h01);
    halt_cnt(n);
    `CHK(n, 0)
    cpu.rd(8'h01, v);
    `CHK(v, 8'h99)
    wait_idle(n);
    cpu.rd(8'h02, v);
    `CHK(v, 8'h05)
    cpu.wr(8'h00, 8'h01);
    cpu.rd(8'h01, v);
    `CHK(v, 8'h3c)
    $display("t_lock done");
  endtask : t_lock

  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_reset();
    t_write();
    t_late();
    t_flash();
    t_lock();
    stop_test();
  end
endmodule : eca_access_ctrl_tb_top

`default_nettype wire
